// ---- src/tup_cfg.svh ----
// Register map, field layout, reset values and field widths of the parameter packer
`ifndef TUP_CFG_SVH
`define TUP_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------------------
`define TUP_ADDR_CONFIG 8'h00
`define TUP_ADDR_CMD 8'h04
`define TUP_ADDR_STATUS 8'h08
`define TUP_ADDR_UVSEL 8'h0C
`define TUP_ADDR_UVIDX 8'h10
`define TUP_ADDR_LAG_BASE 8'h20
`define TUP_ADDR_LAG_END 8'h34
`define TUP_ADDR_GAIN_BASE 8'h40
`define TUP_ADDR_GAIN_END 8'h54

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TUP_CMD_START_BIT 0
`define TUP_STATUS_DONE_BIT 1
`define TUP_UVSEL_SIGN_A_BIT 16
`define TUP_UVSEL_SIGN_B_BIT 17

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TUP_CONFIG_RESET 6'h00

// ----------------------------------------------------------------------------
// Frame geometry and variant ranges
// ----------------------------------------------------------------------------
`define TUP_NB_LAST_SF 3'h3
`define TUP_WB_LAST_SF 3'h4
`define TUP_NB_VAR_MIN 3'h5
`define TUP_NB_VAR_MAX 3'h7
`define TUP_WB_VAR_MIN 3'h1
`define TUP_WB_VAR_MAX 3'h5

// ----------------------------------------------------------------------------
// Field widths in bits
// ----------------------------------------------------------------------------
`define TUP_W_LAG_ABS5 4'h5
`define TUP_W_LAG_ABS6 4'h6
`define TUP_W_LAG_ABS8 4'h8
`define TUP_W_LAG_ABS9 4'h9
`define TUP_W_LAG_ABS10 4'hA
`define TUP_W_DELTA_LO 4'h5
`define TUP_W_DELTA_HI 4'h6
`define TUP_W_GAIN_ALG_LO 4'h3
`define TUP_W_GAIN_ALG_HI 4'h6
`define TUP_W_GAIN_VQ 4'h6
`define TUP_W_GAIN_SQ 4'hC
`define TUP_W_UV_INDEX 4'hD
`define TUP_W_PREFIX_SHORT 4'h2
`define TUP_W_PREFIX_LONG 4'h3

// ----------------------------------------------------------------------------
// Wideband variant prefix codes
// ----------------------------------------------------------------------------
`define TUP_PFX_V1 13'h0000
`define TUP_PFX_V2 13'h0001
`define TUP_PFX_V3 13'h0002
`define TUP_PFX_V4 13'h0006
`define TUP_PFX_V5 13'h0007

// ----------------------------------------------------------------------------
// Unvoiced Gaussian table
// ----------------------------------------------------------------------------
`define TUP_UV_MULT 12'h006
`define TUP_UV_SHIFT 8'h02
`define TUP_UV_TABLE_LEN 8'hBE

`endif

// ---- src/tup_pkg.sv ----
// Types shared by the parameter packer
package tup_pkg;

    typedef enum logic [1:0] {
        TUP_MODE_NB,
        TUP_MODE_WB,
        TUP_MODE_UV,
        TUP_MODE_RSV
    } tup_mode_t;

    typedef enum logic [1:0] {
        TUP_LAG_NONE,
        TUP_LAG_ABS,
        TUP_LAG_DELTA
    } tup_lag_t;

    typedef enum logic [1:0] {
        TUP_GAIN_ALG,
        TUP_GAIN_VQ,
        TUP_GAIN_SQ
    } tup_gain_t;

    typedef enum logic [1:0] {
        TUP_EXC_ZERO,
        TUP_EXC_GLOTTAL,
        TUP_EXC_ADAPTIVE
    } tup_exc_t;

    typedef enum logic [2:0] {
        TUP_ST_IDLE,
        TUP_ST_PREFIX,
        TUP_ST_LAG,
        TUP_ST_GAIN,
        TUP_ST_UVIDX,
        TUP_ST_FIN
    } tup_fsm_t;

    typedef struct packed {
        tup_lag_t lag_kind;
        logic [3:0] lag_w;
        tup_gain_t gain_kind;
        logic [3:0] gain_w;
        tup_exc_t exc;
    } tup_desc_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        tup_mode_t mode;
        logic [2:0] variant;
        logic rate64;
        logic [4:0][9:0] lag;
        logic [4:0][11:0] gain;
        logic [5:0] uv_a;
        logic [5:0] uv_b;
        logic uv_sa;
        logic uv_sb;
        tup_fsm_t fsm;
        logic [2:0] sf;
        logic done;
        logic err;
        logic [7:0] fcount;
        logic [12:0] uv_index;
        logic [7:0] uv_addr1;
        logic [7:0] uv_addr2;
        logic uv_neg1;
        logic uv_neg2;
        logic fvalid;
        logic [12:0] fdata;
        logic [3:0] fwidth;
        logic flast;
        logic [2:0] fsf;
        tup_exc_t fexc;
    } tup_state_t;

endpackage

// ---- src/tup_param_packer.sv ----
// Transition and unvoiced parameter packer with Avalon-MM register slave
// ----------------------------------------------------------------------------
// Summary of operation
// - NB variant 5: lag only in subframes 3 and 4, 9-bit absolute then delta.
// - NB variant 5: subframe 1 carries algebraic fields only, 3-bit gain.
// - NB variant 6: subframes 1 and 2 algebraic only, each with 3-bit gain.
// - NB variant 6: fourth subframe lag still sent as 9-bit absolute code.
// - NB variant 6: third subframe lag sent as 5-bit absolute code.
// - NB variant 7: lag only in subframe 4, 9-bit absolute; others algebraic.
// - NB variant 7: 3-bit gain in subframes 1-3, joint scalar gain in 4.
// - WB variant 1: lag 1 in 6 bits, lag 2 as 8-bit absolute.
// - WB variant 1: lag 3 10-bit absolute, lags 4 and 5 6-bit delta.
// - WB variant 1: full gains everywhere, 6-bit vector or 12-bit scalar by rate.
// - WB variant 2: 6-bit lag 2, 10-bit lag 3, 6-bit deltas 4 and 5.
// - WB variant 2: subframe 1 algebraic gain 3 or 6 bits; others full.
// - WB variant 3: subframes 1-2 algebraic; lag 3 absolute, 4-5 delta.
// - WB variant 4: subframes 1-3 algebraic; lag 4 absolute, lag 5 delta.
// - WB variant 5: only lag 5, 10-bit absolute, with scalar joint gain.
// - WB variant 5: algebraic gain of subframes 1-4 is 3 or 6 bits.
// - Unvoiced excitation from two signed entries of a shift-by-two table.
// - Unvoiced index is 13 bits: two 6-bit indices and one sign.
// - Index equals first sign plus twice first index times six plus second.
// - Equal signs put smaller index first, otherwise the larger first.
// - Each field tags its first-stage excitation source for memory update.
// - Wideband variant sent as prefix code 00, 01, 10, 110, 111.
// ----------------------------------------------------------------------------
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tup_cfg.svh"

module tup_param_packer (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_field_ready,
    output logic o_field_valid,
    output logic [12:0] o_field_data,
    output logic [3:0] o_field_width,
    output logic o_field_last,
    output logic [2:0] o_field_subframe,
    output logic [1:0] o_field_exc,
    output logic o_busy,
    output logic [7:0] o_uv_first_addr,
    output logic [7:0] o_uv_second_addr,
    output logic o_uv_first_neg,
    output logic o_uv_second_neg
);

    tup_pkg::tup_state_t st;
    tup_pkg::tup_state_t next_st;
    tup_pkg::tup_desc_t desc;
    logic wb;
    logic [2:0] last_sf;
    logic cfg_ok;
    logic [5:0] p1;
    logic [5:0] p2;
    logic sig1;
    logic sig2;
    logic [11:0] pair_sum;
    logic [12:0] uv_idx;
    logic emit;
    logic [12:0] e_data;
    logic [3:0] e_w;
    logic e_last;
    logic slot_free;
    logic take_wr;
    logic idle;
    logic [2:0] lag_i;
    logic [2:0] gain_i;
    logic [31:0] cfg_img;

    // ------------------------------------------------------------------------
    // Per-subframe field layout
    // ------------------------------------------------------------------------
    function automatic tup_pkg::tup_desc_t sf_desc(input logic is_wb, input logic [2:0] v,
                                                    input logic r64, input logic [2:0] sf);
        tup_pkg::tup_desc_t d;
        logic [2:0] gs;
        logic [2:0] lst;
        d = '0;
        gs = is_wb ? v - 3'h1 : v - 3'h4;
        lst = is_wb ? `TUP_WB_LAST_SF : `TUP_NB_LAST_SF;
        if (sf < gs) begin
            // Zero first stage: only the algebraic gain is coded
            d.gain_kind = tup_pkg::TUP_GAIN_ALG;
            d.exc = tup_pkg::TUP_EXC_ZERO;
            d.gain_w = (is_wb && r64) ? `TUP_W_GAIN_ALG_HI : `TUP_W_GAIN_ALG_LO;
        end else begin
            d.exc = (sf == gs) ? tup_pkg::TUP_EXC_GLOTTAL : tup_pkg::TUP_EXC_ADAPTIVE;
            if (r64 || (sf == gs && gs == lst)) begin
                d.gain_kind = tup_pkg::TUP_GAIN_SQ;
                d.gain_w = `TUP_W_GAIN_SQ;
            end else begin
                d.gain_kind = tup_pkg::TUP_GAIN_VQ;
                d.gain_w = `TUP_W_GAIN_VQ;
            end
        end
        if (is_wb) begin
            if (sf < gs) begin
                d.lag_kind = tup_pkg::TUP_LAG_NONE;
            end else if (sf > gs && sf >= 3'h3) begin
                d.lag_kind = tup_pkg::TUP_LAG_DELTA;
                d.lag_w = `TUP_W_DELTA_HI;
            end else if (sf >= 3'h2) begin
                d.lag_kind = tup_pkg::TUP_LAG_ABS;
                d.lag_w = `TUP_W_LAG_ABS10;
            end else if (sf == 3'h1 && gs == 3'h0) begin
                d.lag_kind = tup_pkg::TUP_LAG_ABS;
                d.lag_w = `TUP_W_LAG_ABS8;
            end else begin
                d.lag_kind = tup_pkg::TUP_LAG_ABS;
                d.lag_w = `TUP_W_LAG_ABS6;
            end
        end else begin
            case (v)
                3'h5: begin
                    if (sf == 3'h2) begin
                        d.lag_kind = tup_pkg::TUP_LAG_ABS;
                        d.lag_w = `TUP_W_LAG_ABS9;
                    end else if (sf == 3'h3) begin
                        d.lag_kind = tup_pkg::TUP_LAG_DELTA;
                        d.lag_w = r64 ? `TUP_W_DELTA_HI : `TUP_W_DELTA_LO;
                    end
                end
                3'h6: begin
                    if (sf == 3'h2) begin
                        d.lag_kind = tup_pkg::TUP_LAG_ABS;
                        d.lag_w = `TUP_W_LAG_ABS5;
                    end else if (sf == 3'h3) begin
                        d.lag_kind = tup_pkg::TUP_LAG_ABS;
                        d.lag_w = `TUP_W_LAG_ABS9;
                    end
                end
                default: begin
                    if (sf == 3'h3) begin
                        d.lag_kind = tup_pkg::TUP_LAG_ABS;
                        d.lag_w = `TUP_W_LAG_ABS9;
                    end
                end
            endcase
        end
        return d;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Configuration decode and unvoiced index
    // ------------------------------------------------------------------------
    assign wb = (st.mode == tup_pkg::TUP_MODE_WB);
    assign last_sf = wb ? `TUP_WB_LAST_SF : `TUP_NB_LAST_SF;
    assign desc = sf_desc(wb, st.variant, st.rate64, st.sf);
    assign idle = (st.fsm == tup_pkg::TUP_ST_IDLE);
    assign cfg_img = {26'h0, st.rate64, st.variant, st.mode};

    always_comb begin
        case (st.mode)
            tup_pkg::TUP_MODE_NB:
                cfg_ok = st.variant >= `TUP_NB_VAR_MIN && st.variant <= `TUP_NB_VAR_MAX;
            tup_pkg::TUP_MODE_WB:
                cfg_ok = st.variant >= `TUP_WB_VAR_MIN && st.variant <= `TUP_WB_VAR_MAX;
            tup_pkg::TUP_MODE_UV:
                cfg_ok = 1'b1;
            default:
                cfg_ok = 1'b0;
        endcase
    end

    // Sign order carries the second sign, so only one sign bit is sent
    always_comb begin
        if (st.uv_sa == st.uv_sb) begin
            p1 = (st.uv_a > st.uv_b) ? st.uv_b : st.uv_a;
            p2 = (st.uv_a > st.uv_b) ? st.uv_a : st.uv_b;
            sig1 = st.uv_sa;
            sig2 = st.uv_sa;
        end else begin
            p1 = (st.uv_a > st.uv_b) ? st.uv_a : st.uv_b;
            p2 = (st.uv_a > st.uv_b) ? st.uv_b : st.uv_a;
            sig1 = (st.uv_a > st.uv_b) ? st.uv_sa : st.uv_sb;
            sig2 = ~sig1;
        end
        pair_sum = 12'(12'(p1) * `TUP_UV_MULT + 12'(p2));
        uv_idx = {pair_sum, sig1};
    end

    // ------------------------------------------------------------------------
    // Bus slave, packing sequencer and field stream
    // ------------------------------------------------------------------------
    assign slot_free = !st.fvalid || i_field_ready;
    assign take_wr = i_avs_write && st.ack;
    assign lag_i = 3'((i_avs_address - `TUP_ADDR_LAG_BASE) >> 2);
    assign gain_i = 3'((i_avs_address - `TUP_ADDR_GAIN_BASE) >> 2);

    always_comb begin
        next_st = st;
        emit = 1'b0;
        e_data = 13'h0000;
        e_w = 4'h0;
        e_last = 1'b0;

        // One wait state on every access keeps decode off the answer path
        next_st.ack = (i_avs_read || i_avs_write) && !st.ack;
        if (i_avs_read && !st.ack) begin
            if (i_avs_address == `TUP_ADDR_CONFIG) begin
                next_st.rdata = cfg_img;
            end else if (i_avs_address == `TUP_ADDR_STATUS) begin
                next_st.rdata = {16'h0000, st.fcount, 5'h00, st.err, st.done, !idle};
            end else if (i_avs_address == `TUP_ADDR_UVSEL) begin
                next_st.rdata = {14'h0000, st.uv_sb, st.uv_sa, 2'h0, st.uv_b, 2'h0, st.uv_a};
            end else if (i_avs_address == `TUP_ADDR_UVIDX) begin
                next_st.rdata = {st.uv_addr2, st.uv_addr1, 3'h0, st.uv_index};
            end else if (i_avs_address >= `TUP_ADDR_LAG_BASE &&
                         i_avs_address < `TUP_ADDR_LAG_END && i_avs_address[1:0] == 2'h0) begin
                next_st.rdata = {22'h000000, st.lag[lag_i]};
            end else if (i_avs_address >= `TUP_ADDR_GAIN_BASE &&
                         i_avs_address < `TUP_ADDR_GAIN_END && i_avs_address[1:0] == 2'h0) begin
                next_st.rdata = {20'h00000, st.gain[gain_i]};
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end

        // Parameter writes are refused while a frame is being packed
        if (take_wr) begin
            if (i_avs_address == `TUP_ADDR_CONFIG && idle) begin
                {next_st.rate64, next_st.variant, next_st.mode} =
                    6'(merge(cfg_img, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == `TUP_ADDR_STATUS) begin
                if (i_avs_byteenable[0] && i_avs_writedata[`TUP_STATUS_DONE_BIT]) begin
                    next_st.done = 1'b0;
                end
            end else if (i_avs_address == `TUP_ADDR_UVSEL && idle) begin
                if (i_avs_byteenable[0]) begin
                    next_st.uv_a = i_avs_writedata[5:0];
                end
                if (i_avs_byteenable[1]) begin
                    next_st.uv_b = i_avs_writedata[13:8];
                end
                if (i_avs_byteenable[2]) begin
                    next_st.uv_sa = i_avs_writedata[`TUP_UVSEL_SIGN_A_BIT];
                    next_st.uv_sb = i_avs_writedata[`TUP_UVSEL_SIGN_B_BIT];
                end
            end else if (i_avs_address >= `TUP_ADDR_LAG_BASE && idle &&
                         i_avs_address < `TUP_ADDR_LAG_END && i_avs_address[1:0] == 2'h0) begin
                next_st.lag[lag_i] =
                    10'(merge({22'h0, st.lag[lag_i]}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address >= `TUP_ADDR_GAIN_BASE && idle &&
                         i_avs_address < `TUP_ADDR_GAIN_END && i_avs_address[1:0] == 2'h0) begin
                next_st.gain[gain_i] =
                    12'(merge({20'h0, st.gain[gain_i]}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == `TUP_ADDR_CMD && idle && i_avs_byteenable[0] &&
                         i_avs_writedata[`TUP_CMD_START_BIT]) begin
                next_st.sf = 3'h0;
                next_st.fcount = 8'h00;
                next_st.err = !cfg_ok;
                next_st.done = !cfg_ok;
                next_st.uv_index = uv_idx;
                next_st.uv_addr1 = 8'(8'(p1) * `TUP_UV_SHIFT);
                next_st.uv_addr2 = 8'(8'(p2) * `TUP_UV_SHIFT);
                next_st.uv_neg1 = sig1;
                next_st.uv_neg2 = sig2;
                if (!cfg_ok) begin
                    next_st.fsm = tup_pkg::TUP_ST_IDLE;
                end else if (st.mode == tup_pkg::TUP_MODE_WB) begin
                    next_st.fsm = tup_pkg::TUP_ST_PREFIX;
                end else if (st.mode == tup_pkg::TUP_MODE_UV) begin
                    next_st.fsm = tup_pkg::TUP_ST_UVIDX;
                end else begin
                    next_st.fsm = tup_pkg::TUP_ST_LAG;
                end
            end
        end

        if (st.fvalid && i_field_ready) begin
            next_st.fvalid = 1'b0;
        end

        case (st.fsm)
            tup_pkg::TUP_ST_PREFIX: begin
                if (slot_free) begin
                    emit = 1'b1;
                    next_st.fsm = tup_pkg::TUP_ST_LAG;
                    case (st.variant)
                        3'h1: e_data = `TUP_PFX_V1;
                        3'h2: e_data = `TUP_PFX_V2;
                        3'h3: e_data = `TUP_PFX_V3;
                        3'h4: e_data = `TUP_PFX_V4;
                        default: e_data = `TUP_PFX_V5;
                    endcase
                    e_w = (st.variant >= 3'h4) ? `TUP_W_PREFIX_LONG : `TUP_W_PREFIX_SHORT;
                end
            end
            tup_pkg::TUP_ST_LAG: begin
                if (desc.lag_kind == tup_pkg::TUP_LAG_NONE) begin
                    next_st.fsm = tup_pkg::TUP_ST_GAIN;
                end else if (slot_free) begin
                    emit = 1'b1;
                    e_data = {3'h0, st.lag[st.sf]};
                    e_w = desc.lag_w;
                    next_st.fsm = tup_pkg::TUP_ST_GAIN;
                end
            end
            tup_pkg::TUP_ST_GAIN: begin
                if (slot_free) begin
                    emit = 1'b1;
                    e_data = {1'b0, st.gain[st.sf]};
                    e_w = desc.gain_w;
                    e_last = (st.sf == last_sf);
                    next_st.sf = 3'(st.sf + 3'h1);
                    next_st.fsm = e_last ? tup_pkg::TUP_ST_FIN : tup_pkg::TUP_ST_LAG;
                end
            end
            tup_pkg::TUP_ST_UVIDX: begin
                if (slot_free) begin
                    emit = 1'b1;
                    e_data = st.uv_index;
                    e_w = `TUP_W_UV_INDEX;
                    e_last = 1'b1;
                    next_st.fsm = tup_pkg::TUP_ST_FIN;
                end
            end
            tup_pkg::TUP_ST_FIN: begin
                // Done is set after the last field leaves; it wins over a clear
                if (slot_free) begin
                    next_st.done = 1'b1;
                    next_st.fsm = tup_pkg::TUP_ST_IDLE;
                end
            end
            default: begin
            end
        endcase

        if (emit) begin
            next_st.fvalid = 1'b1;
            // Values wider than the field are cut to its width
            next_st.fdata = e_data & ~(13'h1FFF << e_w);
            next_st.fwidth = e_w;
            next_st.flast = e_last;
            next_st.fsf = (st.fsm == tup_pkg::TUP_ST_PREFIX) ? 3'h0 : st.sf;
            next_st.fexc = (st.fsm == tup_pkg::TUP_ST_GAIN || st.fsm == tup_pkg::TUP_ST_LAG) ?
                           desc.exc : tup_pkg::TUP_EXC_ZERO;
            next_st.fcount = 8'(st.fcount + 8'h01);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            st <= '0;
            {st.rate64, st.variant, st.mode} <= `TUP_CONFIG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_avs_readdata = st.rdata;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st.ack;
    assign o_field_valid = st.fvalid;
    assign o_field_data = st.fdata;
    assign o_field_width = st.fwidth;
    assign o_field_last = st.flast;
    assign o_field_subframe = st.fsf;
    assign o_field_exc = st.fexc;
    assign o_busy = !idle;
    assign o_uv_first_addr = st.uv_addr1;
    assign o_uv_second_addr = st.uv_addr2;
    assign o_uv_first_neg = st.uv_neg1;
    assign o_uv_second_neg = st.uv_neg2;

endmodule

// ---- tb/tup_param_packer_props.sv ----
// Port-level assertions for the parameter packer
`timescale 1ns/1ps
module tup_param_packer_props (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic i_field_ready,
    input wire logic o_field_valid,
    input wire logic [12:0] o_field_data,
    input wire logic [3:0] o_field_width,
    input wire logic o_field_last,
    input wire logic [2:0] o_field_subframe,
    input wire logic [1:0] o_field_exc,
    input wire logic o_busy,
    input wire logic [7:0] o_uv_first_addr,
    input wire logic [7:0] o_uv_second_addr,
    input wire logic o_uv_first_neg,
    input wire logic o_uv_second_neg
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_wait_cause: assert property (o_avs_waitrequest |-> i_avs_read || i_avs_write)
        else $error("waitrequest high without a request");
    a_wait_once: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held past one cycle");
    a_field_hold: assert property (o_field_valid && !i_field_ready |=> o_field_valid
        && $stable(o_field_data) && $stable(o_field_width) && $stable(o_field_last))
        else $error("field changed before it was taken");
    a_data_fits: assert property (o_field_valid |-> (o_field_data >> o_field_width) == 13'h0000)
        else $error("field data wider than its width");
    a_width_legal: assert property (o_field_valid |-> o_field_width inside
        {4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD})
        else $error("field width not a coded width");
    a_uv_same: assert property (o_uv_first_neg == o_uv_second_neg |->
        o_uv_first_addr <= o_uv_second_addr) else $error("equal signs not smaller first");
    a_uv_swap: assert property (o_uv_first_neg != o_uv_second_neg |->
        o_uv_first_addr >= o_uv_second_addr) else $error("unequal signs not larger first");
    a_uv_table: assert property (!o_uv_first_addr[0] && !o_uv_second_addr[0]
        && o_uv_first_addr <= 8'h7E && o_uv_second_addr <= 8'h7E) else $error("bad table start");
    a_exc_code: assert property (o_field_valid |-> o_field_exc != 2'h3
        && o_field_subframe <= 3'h4) else $error("bad excitation or subframe");
    a_pfx_short: assert property (o_field_valid && o_field_width == 4'h2 |->
        o_field_data <= 13'h0002) else $error("short prefix out of range");
    a_last_done: assert property (o_field_valid && o_field_last && i_field_ready |=>
        ##[1:3] !o_busy) else $error("busy stays after last field");
endmodule
bind tup_param_packer tup_param_packer_props u_props (.i_core_clk, .i_reset_n, .i_avs_read,
    .i_avs_write, .o_avs_waitrequest, .i_field_ready, .o_field_valid, .o_field_data,
    .o_field_width, .o_field_last, .o_field_subframe, .o_field_exc, .o_busy,
    .o_uv_first_addr, .o_uv_second_addr, .o_uv_first_neg, .o_uv_second_neg);

// ---- tb/tup_field_sink.sv ----
// Stream sink standing in for the remote bitstream parser
`timescale 1ns/1ps
module tup_field_sink (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_stall,
    input wire logic i_valid,
    input wire logic [12:0] i_data,
    input wire logic [3:0] i_width,
    input wire logic i_last,
    output logic o_ready
);
    logic [12:0] q_data[$];
    logic [3:0] q_width[$];
    logic last_seen;
    logic [1:0] phase = 2'h0;
    // Stalls one cycle in four so the packer must hold a field
    always @(posedge i_core_clk) begin
        phase <= phase + 2'h1;
        o_ready <= i_reset_n && !(i_stall && phase == 2'h2);
        if (i_valid && o_ready) begin
            q_data.push_back(i_data);
            q_width.push_back(i_width);
            last_seen <= i_last;
        end
    end
endmodule

// ---- tb/test_tup_param_packer.sv ----
// Register-driven bench of the parameter packer
`timescale 1ns/1ps
`include "tup_cfg.svh"
module test_tup_param_packer;
    logic i_core_clk, i_reset_n, rd, wr, stall, ready, valid, last, busy, wait_req, n1, n2;
    logic [7:0] addr, a1, a2;
    logic [31:0] wdata, rdata, q;
    logic [12:0] data;
    logic [3:0] width;
    int bad_count = 0, checked = 0, cyc = 0;
    tup_param_packer u_dut (.i_core_clk, .i_reset_n, .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_field_ready(ready),
        .o_field_valid(valid), .o_field_data(data), .o_field_width(width), .o_field_last(last),
        .o_field_subframe(), .o_field_exc(), .o_busy(busy), .o_uv_first_addr(a1),
        .o_uv_second_addr(a2), .o_uv_first_neg(n1), .o_uv_second_neg(n2));
    tup_field_sink u_sink (.i_core_clk, .i_reset_n, .i_stall(stall), .i_valid(valid),
        .i_data(data), .i_width(width), .i_last(last), .o_ready(ready));
    always #12.5 i_core_clk = ~i_core_clk;
    task finish_test;
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            finish_test;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        addr <= a; rd <= !w; wr <= w; wdata <= d;
        do @(negedge i_core_clk); while (wait_req !== 1'b0);
        @(posedge i_core_clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Widths in emission order, one hex digit per field
    task run(input logic [5:0] cfg, input string w, input logic [12:0] pfx);
        u_sink.q_width.delete();
        u_sink.q_data.delete();
        bus(1'b1, `TUP_ADDR_CONFIG, {26'h0, cfg});
        bus(1'b1, `TUP_ADDR_CMD, 32'h1);
        repeat (2) @(posedge i_core_clk);
        while (busy !== 1'b0) @(posedge i_core_clk);
        repeat (3) @(posedge i_core_clk);
        chk(u_sink.q_width.size(), w.len());
        for (int i = 0; i < w.len() && i < u_sink.q_width.size(); i++)
            chk(u_sink.q_width[i], (w[i] > 8'h40) ? w[i] - 8'h37 : w[i] - 8'h30);
        if (w.len() > 0) chk(u_sink.last_seen, 1'b1);
        if (cfg[1:0] == 2'h1) chk(u_sink.q_data[0], pfx);
    endtask
    initial begin
        i_core_clk = 0; i_reset_n = 0; rd = 0; wr = 0; addr = 0; wdata = 0; stall = 0;
        repeat (10) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        bus(1'b0, `TUP_ADDR_CONFIG, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h7C, 32'h0);
        chk(q, 32'h0);
        run(6'h14, "369656", 0);
        stall <= 1'b1;
        run(6'h34, "3C9C6C", 0);
        run(6'h18, "335696", 0);
        run(6'h1C, "3339C", 0);
        run(6'h05, "26686A66666", `TUP_PFX_V1);
        run(6'h25, "26C8CAC6C6C", `TUP_PFX_V1);
        run(6'h09, "2366A66666", `TUP_PFX_V2);
        run(6'h0D, "233A66666", `TUP_PFX_V3);
        run(6'h31, "3666AC6C", `TUP_PFX_V4);
        run(6'h15, "33333AC", `TUP_PFX_V5);
        run(6'h35, "36666AC", `TUP_PFX_V5);
        run(6'h03, "", 0);
        bus(1'b0, `TUP_ADDR_STATUS, 32'h0);
        chk(q[2:0], 3'h6);
        bus(1'b1, `TUP_ADDR_UVSEL, 32'h0000_1405);
        run(6'h02, "D", 0);
        chk(u_sink.q_data[0], 13'h0064);
        bus(1'b0, `TUP_ADDR_UVIDX, 32'h0);
        chk(q, 32'h280A_0064);
        bus(1'b1, `TUP_ADDR_UVSEL, 32'h0002_1405);
        run(6'h02, "D", 0);
        chk(u_sink.q_data[0], 13'h00FB);
        chk({a1, a2, n1, n2}, {8'h28, 8'h0A, 2'h2});
        finish_test;
    end
endmodule
